// ==== hdl/esr_pkg.sv ====
// esr_pkg: constants, types and register map of the speed reference selector.
// assumes speeds are held in units of 0.01 Hz, one 16-bit word per setpoint.
package esr_pkg;

	localparam int unsigned ESR_SPD_W   = 16;
	localparam int unsigned ESR_IDX_W   = 4;
	localparam int unsigned ESR_ADDR_W  = 8;
	localparam int unsigned ESR_NWORDS  = 16;

	// setpoint slots in the memory
	localparam logic [3:0] ESR_IDX_PRESET0  = 4'h0;
	localparam logic [3:0] ESR_IDX_NOMINAL  = 4'h8;
	localparam logic [3:0] ESR_IDX_INTERM1  = 4'h9;
	localparam logic [3:0] ESR_IDX_INTERM2  = 4'ha;
	localparam logic [3:0] ESR_IDX_INTERM3  = 4'hb;
	localparam logic [3:0] ESR_IDX_RELEVEL  = 4'hc;
	localparam logic [3:0] ESR_IDX_INSPECT  = 4'hd;
	localparam logic [3:0] ESR_IDX_RESCUE   = 4'he;
	localparam logic [3:0] ESR_IDX_LEVEL    = 4'hf;

	// setpoint limits and defaults, 0.01 Hz units
	localparam logic [15:0] ESR_SPD_MAX         = 16'h2ee0;
	localparam logic [15:0] ESR_RESCUE_MAX      = 16'h05dc;
	localparam logic [15:0] ESR_NOMINAL_DEFAULT = 16'h1388;
	localparam logic [15:0] ESR_RESCUE_DEFAULT  = 16'h01f4;
	localparam logic [15:0] ESR_LEVEL_DEFAULT   = 16'h0190;
	localparam logic [15:0] ESR_ZERO_SPEED      = 16'h0000;

	// reference selection modes
	localparam logic [1:0] ESR_MODE_BINARY   = 2'h0;
	localparam logic [1:0] ESR_MODE_HIGH_PRI = 2'h1;
	localparam logic [1:0] ESR_MODE_LEV_PRI  = 2'h2;
	localparam logic [1:0] ESR_MODE_BINARY3  = 2'h3;
	localparam logic [1:0] ESR_MODE_DEFAULT  = 2'h1;

	// register byte offsets
	localparam logic [7:0] ESR_OFS_CTRL     = 8'h00;
	localparam logic [7:0] ESR_OFS_STATUS   = 8'h04;
	localparam logic [7:0] ESR_OFS_LEV_THR  = 8'h08;
	localparam logic [7:0] ESR_OFS_INSP_THR = 8'h0c;
	localparam logic [7:0] ESR_OFS_SP_BASE  = 8'h40;
	localparam logic [1:0] ESR_OFS_SP_TOP   = 2'h1;

	// field positions
	localparam int unsigned ESR_CTRL_MODE_LSB  = 0;
	localparam int unsigned ESR_STAT_LEV_BIT   = 16;
	localparam int unsigned ESR_STAT_INSP_BIT  = 17;
	localparam int unsigned ESR_STAT_VALID_BIT = 18;
	localparam int unsigned ESR_STAT_IDX_LSB   = 20;

	typedef enum logic [1:0] {
		ESR_REG_NONE,
		ESR_REG_CTRL,
		ESR_REG_THR,
		ESR_REG_SP
	} esr_kind_t;

	typedef enum logic {
		ESR_APB_IDLE = 1'b0,
		ESR_APB_ACK  = 1'b1
	} esr_apb_st_t;

	// dedicated and multi-speed input functions
	typedef struct packed {
		logic       rescue;
		logic       nominal;
		logic [2:0] interm;
		logic       relevel;
		logic       inspect;
		logic       level;
		logic [2:0] multi;
	} esr_din_t;

	typedef struct packed {
		logic       valid;
		logic [3:0] idx;
	} esr_sel_t;

	typedef struct packed {
		esr_kind_t  kind;
		logic [3:0] idx;
	} esr_dec_t;

	// reset value of each setpoint slot
	function automatic logic [15:0] esr_sp_default(input logic [3:0] idx);
		case (idx)
			ESR_IDX_NOMINAL: esr_sp_default = ESR_NOMINAL_DEFAULT;
			ESR_IDX_RESCUE:  esr_sp_default = ESR_RESCUE_DEFAULT;
			ESR_IDX_LEVEL:   esr_sp_default = ESR_LEVEL_DEFAULT;
			default:         esr_sp_default = ESR_ZERO_SPEED;
		endcase
	endfunction

endpackage

// ==== hdl/esr_setpoint_mem.sv ====
// esr_setpoint_mem: sixteen speed setpoints, one write/read port, one read port.
// assumes a synchronised active-low reset; both read data come out of registers.
`timescale 1ns/10ps
module esr_setpoint_mem
	import esr_pkg::*;
(
	// clock and reset
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	// register port
	input  wire logic [ESR_IDX_W-1:0]      a_addr,
	input  wire logic                      a_we,
	input  wire logic [ESR_SPD_W-1:0]      a_wdata,
	output logic      [ESR_SPD_W-1:0]      a_rdata,
	// selection port
	input  wire logic [ESR_IDX_W-1:0]      b_addr,
	output logic      [ESR_SPD_W-1:0]      b_rdata
);
	import esr_pkg::*;

	logic [ESR_SPD_W-1:0] word_r   [ESR_NWORDS];
	logic [ESR_SPD_W-1:0] word_nxt [ESR_NWORDS];

	genvar gi;
	generate
		for (gi = 0; gi < ESR_NWORDS; gi++) begin : g_word
			always_comb begin
				word_nxt[gi] = word_r[gi];
				if (a_we && a_addr == ESR_IDX_W'(gi)) begin
					word_nxt[gi] = a_wdata;
				end
			end
			// reset values come from a constant table, never from a port
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					word_r[gi] <= esr_sp_default(ESR_IDX_W'(gi));
				end else begin
					word_r[gi] <= word_nxt[gi];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			a_rdata <= ESR_ZERO_SPEED;
			b_rdata <= ESR_ZERO_SPEED;
		end else begin
			a_rdata <= word_r[a_addr];
			b_rdata <= word_r[b_addr];
		end
	end

endmodule

// ==== hdl/esr_top.sv ====
// esr_top: elevator speed reference selection with an APB register slave.
// assumes input terminals are asynchronous levels and APB runs on CLOCK.
`timescale 1ns/10ps

// Notes on behaviour
// - An asserted nominal speed input selects the nominal setpoint, which resets to 50.00 Hz.
// - Three intermediate setpoints are held, each 0 to 120.00 Hz and resetting to zero.
// - An asserted releveling input selects the releveling setpoint.
// - An asserted inspection input selects the inspection setpoint.
// - Rescue operation uses its own setpoint, capped at 15.00 Hz and resetting to 5.00 Hz.
// - An asserted leveling input selects the leveling setpoint, which resets to 4.00 Hz.
// - In modes 0 and 3 a reference below the leveling threshold is flagged as leveling.
// - In modes 0 and 3 a reference between leveling and inspection thresholds is inspection.
// - In mode 1 nominal, intermediate and releveling inputs win over the leveling input.
// - In mode 2 an asserted leveling input overrides every other speed input except rescue.
// - In mode 0 the multi-speed inputs form a binary code picking one of eight presets.
module esr_top
	import esr_pkg::*;
(
	// clock and reset
	input  wire logic                  CLOCK,
	input  wire logic                  RESET_N,
	// apb slave
	input  wire logic                  PSEL,
	input  wire logic                  PENABLE,
	input  wire logic                  PWRITE,
	input  wire logic [ESR_ADDR_W-1:0] PADDR,
	input  wire logic [31:0]           PWDATA,
	output logic      [31:0]           PRDATA,
	output logic                       PREADY,
	output logic                       PSLVERR,
	// input terminal functions
	input  wire esr_pkg::esr_din_t     DIN,
	// speed reference out
	output logic      [ESR_SPD_W-1:0]  SPEED_REF,
	output logic                       REF_VALID,
	output logic                       LEVEL_CLASS,
	output logic                       INSPECT_CLASS
);
	import esr_pkg::*;

	// decode of a byte address, shared by the read and write paths
	function automatic esr_dec_t esr_decode(input logic [ESR_ADDR_W-1:0] a);
		esr_dec_t d;
		d.kind = ESR_REG_NONE;
		d.idx  = a[5:2];
		if (a[1:0] == 2'h0) begin
			if (a == ESR_OFS_CTRL || a == ESR_OFS_STATUS) begin
				d.kind = ESR_REG_CTRL;
			end else if (a == ESR_OFS_LEV_THR || a == ESR_OFS_INSP_THR) begin
				d.kind = ESR_REG_THR;
			end else if (a[7:6] == ESR_OFS_SP_TOP) begin
				d.kind = ESR_REG_SP;
			end
		end
		return d;
	endfunction

	// reset release
	logic rst_meta_r;
	logic rst_n_r;

	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			rst_meta_r <= 1'b0;
			rst_n_r    <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r    <= rst_meta_r;
		end
	end

	// terminal synchroniser; first stage feeds only the second
	esr_din_t din_meta_r;
	esr_din_t din_r;

	always_ff @(posedge CLOCK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			din_meta_r <= '0;
			din_r      <= '0;
		end else begin
			din_meta_r <= DIN;
			din_r      <= din_meta_r;
		end
	end

	// configuration registers
	logic [1:0]           mode_r;
	logic [1:0]           mode_nxt;
	logic [ESR_SPD_W-1:0] lev_thr_r;
	logic [ESR_SPD_W-1:0] lev_thr_nxt;
	logic [ESR_SPD_W-1:0] insp_thr_r;
	logic [ESR_SPD_W-1:0] insp_thr_nxt;

	// apb slave state
	esr_apb_st_t          apb_st_r;
	esr_apb_st_t          apb_st_nxt;
	logic [31:0]          prdata_nxt;
	logic                 pslverr_nxt;
	esr_dec_t             dec;
	logic                 wr_fire;
	logic                 mem_we;
	logic [ESR_SPD_W-1:0] mem_wdata;
	logic [ESR_SPD_W-1:0] mem_a_rdata;
	logic [ESR_SPD_W-1:0] wdata_lim;

	// selection pipeline
	esr_sel_t             sel;
	esr_sel_t             sel_d_r;
	logic [1:0]           mode_d_r;
	logic [ESR_SPD_W-1:0] mem_b_rdata;
	logic [ESR_SPD_W-1:0] ref_nxt;
	logic                 ref_valid_nxt;
	logic                 lev_nxt;
	logic                 insp_nxt;
	// index kept beside the reference so status never shows a mismatched pair
	logic [ESR_IDX_W-1:0] ref_idx_r;

	always_comb begin
		dec        = esr_decode(PADDR);
		wr_fire    = PSEL && PENABLE && PWRITE && (apb_st_r == ESR_APB_ACK);
		apb_st_nxt = ESR_APB_IDLE;
		if (PSEL && PENABLE && apb_st_r == ESR_APB_IDLE) begin
			apb_st_nxt = ESR_APB_ACK;
		end
		// out-of-range writes saturate instead of being refused
		wdata_lim = PWDATA[ESR_SPD_W-1:0];
		if (PWDATA[31:ESR_SPD_W] != '0 || wdata_lim > ESR_SPD_MAX) begin
			wdata_lim = ESR_SPD_MAX;
		end
		mem_wdata = wdata_lim;
		if (dec.idx == ESR_IDX_RESCUE && wdata_lim > ESR_RESCUE_MAX) begin
			mem_wdata = ESR_RESCUE_MAX;
		end
		mem_we = wr_fire && dec.kind == ESR_REG_SP;
	end

	always_comb begin
		mode_nxt     = mode_r;
		lev_thr_nxt  = lev_thr_r;
		insp_thr_nxt = insp_thr_r;
		if (wr_fire) begin
			if (PADDR == ESR_OFS_CTRL) begin
				mode_nxt = PWDATA[ESR_CTRL_MODE_LSB +: 2];
			end
			if (PADDR == ESR_OFS_LEV_THR) begin
				lev_thr_nxt = wdata_lim;
			end
			if (PADDR == ESR_OFS_INSP_THR) begin
				insp_thr_nxt = wdata_lim;
			end
		end
	end

	// read data is taken while entering the ack cycle
	always_comb begin
		prdata_nxt  = '0;
		pslverr_nxt = 1'b0;
		if (apb_st_nxt == ESR_APB_ACK) begin
			pslverr_nxt = (dec.kind == ESR_REG_NONE);
			if (!PWRITE) begin
				case (dec.kind)
					ESR_REG_CTRL: begin
						if (PADDR == ESR_OFS_CTRL) begin
							prdata_nxt[ESR_CTRL_MODE_LSB +: 2] = mode_r;
						end else begin
							prdata_nxt[ESR_SPD_W-1:0]             = SPEED_REF;
							prdata_nxt[ESR_STAT_LEV_BIT]          = LEVEL_CLASS;
							prdata_nxt[ESR_STAT_INSP_BIT]         = INSPECT_CLASS;
							prdata_nxt[ESR_STAT_VALID_BIT]        = REF_VALID;
							prdata_nxt[ESR_STAT_IDX_LSB +: 4]     = ref_idx_r;
						end
					end
					ESR_REG_THR: begin
						prdata_nxt[ESR_SPD_W-1:0] =
							(PADDR == ESR_OFS_LEV_THR) ? lev_thr_r : insp_thr_r;
					end
					ESR_REG_SP: begin
						prdata_nxt[ESR_SPD_W-1:0] = mem_a_rdata;
					end
					default: begin
						prdata_nxt = '0;
					end
				endcase
			end
		end
	end

	always_ff @(posedge CLOCK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			apb_st_r   <= ESR_APB_IDLE;
			PREADY     <= 1'b0;
			PRDATA     <= '0;
			PSLVERR    <= 1'b0;
			mode_r     <= ESR_MODE_DEFAULT;
			lev_thr_r  <= ESR_ZERO_SPEED;
			insp_thr_r <= ESR_ZERO_SPEED;
		end else begin
			apb_st_r   <= apb_st_nxt;
			PREADY     <= (apb_st_nxt == ESR_APB_ACK);
			PRDATA     <= prdata_nxt;
			PSLVERR    <= pslverr_nxt;
			mode_r     <= mode_nxt;
			lev_thr_r  <= lev_thr_nxt;
			insp_thr_r <= insp_thr_nxt;
		end
	end

	// source selection; rescue sits above every mode
	always_comb begin
		sel.valid = 1'b1;
		sel.idx   = ESR_IDX_PRESET0;
		if (din_r.rescue) begin
			sel.idx = ESR_IDX_RESCUE;
		end else begin
			case (mode_r)
				ESR_MODE_BINARY, ESR_MODE_BINARY3: begin
					sel.idx = {1'b0, din_r.multi};
				end
				ESR_MODE_HIGH_PRI, ESR_MODE_LEV_PRI: begin
					if (mode_r == ESR_MODE_LEV_PRI && din_r.level) begin
						sel.idx = ESR_IDX_LEVEL;
					end else if (din_r.nominal) begin
						sel.idx = ESR_IDX_NOMINAL;
					end else if (din_r.interm[0]) begin
						sel.idx = ESR_IDX_INTERM1;
					end else if (din_r.interm[1]) begin
						sel.idx = ESR_IDX_INTERM2;
					end else if (din_r.interm[2]) begin
						sel.idx = ESR_IDX_INTERM3;
					end else if (din_r.relevel) begin
						sel.idx = ESR_IDX_RELEVEL;
					end else if (din_r.inspect) begin
						sel.idx = ESR_IDX_INSPECT;
					end else if (din_r.level) begin
						sel.idx = ESR_IDX_LEVEL;
					end else begin
						sel.valid = 1'b0;
					end
				end
				default: begin
					sel.valid = 1'b0;
				end
			endcase
		end
	end

	// memory read is one cycle, so the choice and mode travel beside it
	always_ff @(posedge CLOCK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			sel_d_r  <= '0;
			mode_d_r <= ESR_MODE_DEFAULT;
		end else begin
			sel_d_r  <= sel;
			mode_d_r <= mode_r;
		end
	end

	esr_setpoint_mem u_mem (
		.clk     (CLOCK),
		.rst_n   (rst_n_r),
		.a_addr  (dec.idx),
		.a_we    (mem_we),
		.a_wdata (mem_wdata),
		.a_rdata (mem_a_rdata),
		.b_addr  (sel.idx),
		.b_rdata (mem_b_rdata)
	);

	// classification of the chosen reference
	always_comb begin
		ref_valid_nxt = sel_d_r.valid;
		ref_nxt       = sel_d_r.valid ? mem_b_rdata : ESR_ZERO_SPEED;
		lev_nxt       = 1'b0;
		insp_nxt      = 1'b0;
		if (mode_d_r == ESR_MODE_BINARY || mode_d_r == ESR_MODE_BINARY3) begin
			// zero thresholds leave both flags off, as intended
			if (ref_nxt < lev_thr_r) begin
				lev_nxt = 1'b1;
			end else if (ref_nxt < insp_thr_r && ref_nxt > lev_thr_r) begin
				insp_nxt = 1'b1;
			end
		end else if (sel_d_r.valid) begin
			lev_nxt  = (sel_d_r.idx == ESR_IDX_LEVEL);
			insp_nxt = (sel_d_r.idx == ESR_IDX_INSPECT);
		end
	end

	always_ff @(posedge CLOCK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			SPEED_REF     <= ESR_ZERO_SPEED;
			REF_VALID     <= 1'b0;
			LEVEL_CLASS   <= 1'b0;
			INSPECT_CLASS <= 1'b0;
			ref_idx_r     <= ESR_IDX_PRESET0;
		end else begin
			SPEED_REF     <= ref_nxt;
			REF_VALID     <= ref_valid_nxt;
			LEVEL_CLASS   <= lev_nxt;
			INSPECT_CLASS <= insp_nxt;
			ref_idx_r     <= sel_d_r.idx;
		end
	end

endmodule

// ==== verification/esr_top_properties.sv ====
// esr_top_checker: port-level properties of the speed reference selector.
// assumes it is bound to esr_top and sees only its ports.
`timescale 1ns/10ps
module esr_top_checker
	import esr_pkg::*;
(
	// clock and reset
	input wire logic            CLOCK,
	input wire logic            RESET_N,
	// apb
	input wire logic            PSEL,
	input wire logic            PENABLE,
	input wire logic [31:0]     PRDATA,
	input wire logic            PREADY,
	input wire logic            PSLVERR,
	// selection
	input wire esr_pkg::esr_din_t DIN,
	input wire logic [15:0]     SPEED_REF,
	input wire logic            REF_VALID,
	input wire logic            LEVEL_CLASS,
	input wire logic            INSPECT_CLASS
);
	import esr_pkg::*;

	logic [3:0] live_r;
	logic [3:0] live_nxt;

	// the reset synchroniser and input pipeline need a few edges to fill
	always_comb begin
		live_nxt = (live_r == 4'hf) ? live_r : live_r + 4'h1;
	end
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			live_r <= 4'h0;
		end else begin
			live_r <= live_nxt;
		end
	end

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RESET_N);

	property p_ready_pulse; PREADY |=> !PREADY; endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
	property p_ready_time; $rose(PENABLE) && PSEL |-> !PREADY ##1 PREADY; endproperty
	a_ready_time: assert property (p_ready_time) else $error("ready not after one wait state");
	property p_ready_cause; PREADY |-> PSEL && PENABLE && $past(PSEL && PENABLE); endproperty
	a_ready_cause: assert property (p_ready_cause) else $error("ready without access phase");
	property p_err_ready; PSLVERR |-> PREADY; endproperty
	a_err_ready: assert property (p_err_ready) else $error("error without ready");
	property p_rdata_idle; !PREADY |-> PRDATA == 32'h0; endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");
	property p_zero_invalid; !REF_VALID |-> SPEED_REF == 16'h0; endproperty
	a_zero_invalid: assert property (p_zero_invalid) else $error("speed without source");
	property p_class_excl; !(LEVEL_CLASS && INSPECT_CLASS); endproperty
	a_class_excl: assert property (p_class_excl) else $error("both classes at once");
	property p_class_valid; LEVEL_CLASS || INSPECT_CLASS |-> REF_VALID; endproperty
	a_class_valid: assert property (p_class_valid) else $error("class without source");
	property p_rescue; (live_r == 4'hf && DIN.rescue)[*5] |=> REF_VALID; endproperty
	a_rescue: assert property (p_rescue) else $error("rescue gives no reference");
	property p_nominal; (live_r == 4'hf && DIN.nominal && !DIN.rescue)[*5] |=> REF_VALID; endproperty
	a_nominal: assert property (p_nominal) else $error("nominal gives no reference");
	property p_hold; (live_r == 4'hf && $stable(DIN) && !PSEL)[*6] |-> $stable(SPEED_REF); endproperty
	a_hold: assert property (p_hold) else $error("reference moved with inputs held");
endmodule

bind esr_top esr_top_checker u_chk (
	.CLOCK        (CLOCK),
	.RESET_N      (RESET_N),
	.PSEL         (PSEL),
	.PENABLE      (PENABLE),
	.PRDATA       (PRDATA),
	.PREADY       (PREADY),
	.PSLVERR      (PSLVERR),
	.DIN          (DIN),
	.SPEED_REF    (SPEED_REF),
	.REF_VALID    (REF_VALID),
	.LEVEL_CLASS  (LEVEL_CLASS),
	.INSPECT_CLASS(INSPECT_CLASS)
);

// ==== verification/esr_ctrl_model.sv ====
// esr_ctrl_model: elevator controller driving the input terminals.
// assumes the bench gives the wanted terminal pattern; levels change after an edge.
`timescale 1ns/10ps
module esr_ctrl_model
	import esr_pkg::*;
(
	// clock
	input  wire logic             clk,
	// wanted terminal pattern and terminals
	input  wire esr_pkg::esr_din_t cmd,
	output esr_pkg::esr_din_t     din
);
	import esr_pkg::*;

	// terminals are plain levels: registered so they never move on the sampling edge
	always_ff @(posedge clk) begin
		din <= cmd;
	end
endmodule

// ==== verification/test_elevator_speed_reference_select.sv ====
// test_elevator_speed_reference_select: directed bench for esr_top.
// assumes esr_ctrl_model on the terminals and an APB master in the bench.
`timescale 1ns/10ps
module test_elevator_speed_reference_select;
	import esr_pkg::*;
	logic        clock = 1'b0;
	logic        reset_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	esr_din_t    cmd = '0;
	esr_din_t    din;
	logic [15:0] speed_ref;
	logic        ref_valid;
	logic        level_class;
	logic        inspect_class;
	int          num_errors = 0;
	int          compares = 0;

	always #4 clock = ~clock;

	esr_top dut_u (.CLOCK(clock), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .DIN(din), .SPEED_REF(speed_ref), .REF_VALID(ref_valid),
		.LEVEL_CLASS(level_class), .INSPECT_CLASS(inspect_class));
	esr_ctrl_model model_u (.clk(clock), .cmd(cmd), .din(din));

	task automatic print_verdict();
		if (num_errors == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one transfer; holds everything until pready is seen at a rising edge or 50 edges have passed
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 50);
		r = prdata;
		e = pslverr;
		// a transfer that never gets its answer counts as a mismatch
		chk({31'h0, pready}, 32'h1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, exp);
	endtask

	function automatic logic [7:0] spa(input int i);
		return ESR_OFS_SP_BASE + 8'(4 * i);
	endfunction

	// fl is {valid, leveling, inspection}; waits past the four-edge input path
	task automatic sel(input logic [10:0] b, input logic [15:0] spd, input logic [2:0] fl);
		@(posedge clock);
		cmd <= esr_din_t'(b);
		repeat (7) @(posedge clock);
		chk({13'h0, ref_valid, level_class, inspect_class, speed_ref}, {13'h0, fl, spd});
	endtask

	task automatic t_defaults();
		rd(ESR_OFS_CTRL, 32'h1);
		rd(ESR_OFS_LEV_THR, 32'h0);
		rd(ESR_OFS_INSP_THR, 32'h0);
		rd(spa(8), 32'h1388);
		rd(spa(9), 32'h0);
		rd(spa(14), 32'h01f4);
		rd(spa(15), 32'h0190);
		sel(11'h000, 16'h0, 3'b000);
	endtask

	task automatic t_bus();
		logic [31:0] r;
		logic        e;
		apb(1'b0, 8'h10, 32'h0, r, e);
		chk({31'h0, e}, 32'h1);
		chk(r, 32'h0);
		apb(1'b1, 8'h41, 32'h5, r, e);
		chk({31'h0, e}, 32'h1);
		rd(spa(0), 32'h0);
	endtask

	task automatic t_saturate();
		wr(spa(9), 32'h3000);
		rd(spa(9), 32'h2ee0);
		wr(spa(9), 32'h2ee0);
		rd(spa(9), 32'h2ee0);
		wr(spa(10), 32'h0001_0005);
		rd(spa(10), 32'h2ee0);
		wr(spa(14), 32'h07d0);
		rd(spa(14), 32'h05dc);
		sel(11'h600, 16'h05dc, 3'b100);
	endtask

	task automatic t_mode1();
		logic [10:0] bt[5];
		bt = '{11'h040, 11'h080, 11'h100, 11'h020, 11'h010};
		for (int i = 9; i < 14; i++) begin
			wr(spa(i), 32'(100 * i));
		end
		for (int k = 0; k < 5; k++) begin
			sel(bt[k], 16'(100 * (k + 9)), (k == 4) ? 3'b101 : 3'b100);
		end
		sel(11'h008, 16'h0190, 3'b110);
		sel(11'h208, 16'h1388, 3'b100);
		sel(11'h028, 16'h04b0, 3'b100);
		rd(ESR_OFS_STATUS, 32'h00c4_04b0);
	endtask

	task automatic t_mode2();
		wr(ESR_OFS_CTRL, 32'h2);
		sel(11'h208, 16'h0190, 3'b110);
		sel(11'h200, 16'h1388, 3'b100);
		sel(11'h000, 16'h0, 3'b000);
	endtask

	task automatic t_mode0();
		wr(ESR_OFS_CTRL, 32'h0);
		for (int i = 0; i < 8; i++) begin
			wr(spa(i), 32'(100 * (i + 1)));
		end
		for (int c = 0; c < 8; c++) begin
			sel(11'h200 | 11'(c), 16'(100 * (c + 1)), 3'b100);
		end
	endtask

	// threshold equality gives neither class; below both is leveling only
	task automatic t_classify();
		logic [2:0] fl[7];
		fl = '{3'b110, 3'b110, 3'b100, 3'b101, 3'b101, 3'b100, 3'b100};
		wr(ESR_OFS_CTRL, 32'h3);
		wr(ESR_OFS_LEV_THR, 32'h012c);
		wr(ESR_OFS_INSP_THR, 32'h0258);
		for (int c = 0; c < 7; c++) begin
			sel(11'(c), 16'(100 * (c + 1)), fl[c]);
		end
	endtask

	// a mid-run reset must bring back the mode, leveling threshold and setpoint 9 and 14 defaults, written ones too
	task automatic t_reset();
		@(posedge clock);
		reset_n <= 1'b0;
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		repeat (4) @(posedge clock);
		rd(ESR_OFS_CTRL, 32'h1);
		rd(ESR_OFS_LEV_THR, 32'h0);
		rd(spa(9), 32'h0);
		rd(spa(14), 32'h01f4);
		sel(11'h000, 16'h0, 3'b000);
	endtask

	initial begin
		repeat (8) @(posedge clock);
		reset_n <= 1'b1;
		repeat (4) @(posedge clock);
		t_defaults();
		t_bus();
		t_saturate();
		t_mode1();
		t_mode2();
		t_mode0();
		t_classify();
		t_reset();
		print_verdict();
	end

	// the whole sequence needs well under two thousand cycles
	initial begin
		repeat (6000) @(posedge clock);
		num_errors++;
		print_verdict();
	end
endmodule
